// >>> tb/irrbg_ir_src.sv
`timescale 1ns/1ps
// ****************************************
// ir source model
// ****************************************
module irrbg_ir_src (
  input  wire logic clk,   // bench clock
  output logic      ir_in  // ir pin, idle high
);
  // idle line is pulled up, so a released pin reads high
  initial ir_in = 1'b1;
  // one frame, lsb first; bit 0 low is the pulse that wakes the receiver
  task automatic send(input logic [7:0] v, input int per);
    for (int i = 0; i < 8; i++) begin
      ir_in <= v[i];
      repeat (per) @(posedge clk);
    end
    ir_in <= 1'b1;
  endtask : send
endmodule : irrbg_ir_src

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb_top;
  import irrbg_pkg::*;
  localparam logic [7:0] VER = 8'h3c; // arbitrary value
  logic       clk     = 1'b0;
  logic       reset_n = 1'b0;
  irrbg_bus_t bus     = '0;
  logic [7:0] rdata;
  logic       ir_in;
  logic       irq;
  int         num_errors  = 0;
  int         comparisons = 0;
  logic [7:0] q[$];           // model of the receive fifo
  logic [7:0] d;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  irrbg_top #(.VERSION_VALUE(VER), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .ir_in(ir_in), .irq(irq));
  irrbg_ir_src src (.clk(clk), .ir_in(ir_in));

  // compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(n, rdata, e);
  endtask : rc

  // one received byte, then the receiver is stopped by software
  task automatic frame(input logic fast, input logic [7:0] div, input int per);
    logic [7:0] v;
    v = 8'($urandom) & 8'hfe;
    wr(ADDR_DIV_LOW, div);
    wr(ADDR_CONTROL, {6'h00, fast, 1'b0});
    @(posedge clk);
    src.send(v, per);
    // half a bit of slack so the last sample has landed
    repeat (per / 2) @(posedge clk);
    q.push_back(v);
    rc("status", ADDR_RX_STATUS, {3'b110, 5'(q.size())});
    rc("status", ADDR_RX_STATUS, {3'b100, 5'(q.size())});
    wr(ADDR_RX_STATUS, 8'hff);
    rc("status", ADDR_RX_STATUS, {3'b000, 5'(q.size())});
    // an idle high line would fill a byte of ones if still sampling
    repeat (9 * per) @(posedge clk);
    rc("status", ADDR_RX_STATUS, {3'b000, 5'(q.size())});
  endtask : frame

  // single exit point for pass and fail
  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    void'($urandom(94444));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rc("status", ADDR_RX_STATUS, STATUS_RESET);
    rc("div low", ADDR_DIV_LOW, DIV_RESET);
    rc("div high", ADDR_DIV_HIGH, DIV_RESET);
    wr(ADDR_VERSION, ~VER);
    rc("version", ADDR_VERSION, VER);
    rc("unmapped", 4'h5, 8'h00);
    d = 8'($urandom);
    wr(ADDR_DIV_HIGH, d);
    rc("div high", ADDR_DIV_HIGH, d);
    wr(ADDR_DIV_HIGH, 8'h00);
    frame(1'b1, 8'h01, 16);
    // interrupt: masked, raised, cleared
    rc("irq stat", ADDR_IRQ_STAT, 8'h03);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_EN, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_CLR, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {7'h00, irq}, 8'h00);
    rc("irq stat", ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_EN, 8'h00);
    frame(1'b1, 8'h02, 32);
    frame(1'b0, 8'h01, 208);
    // drain by the level count, oldest byte first
    while (q.size() > 0) begin
      d = q.pop_front();
      rc("rx buffer", ADDR_RX_BUFFER, d);
      rc("level", ADDR_RX_STATUS, {3'b000, 5'(q.size())});
    end
    final_report();
  end

  // watchdog, well beyond the three frames
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : tb_top

// >>> verilog/irrbg_baud.sv
`timescale 1ns/1ps
// baud generator: prescaler then 16-bit divisor, one-cycle tick at 16x baud
module irrbg_baud (
  input  wire logic        clk,        // system clock
  input  wire logic        reset_n,    // async reset, active low
  input  wire logic        high_speed, // prescaler bypass
  input  wire logic [15:0] divisor,    // divisor, zero stops ticks
  output logic             tick        // 16x sample pulse
);
  import irrbg_pkg::*;

  logic [3:0]  pre_cnt_r;
  logic [15:0] div_cnt_r;
  logic        pre_tick;

  // ****************************************
  // prescaler
  // ****************************************
  // /13 normally, /1 in fast mode
  assign pre_tick = high_speed || (pre_cnt_r == PRESCALE_NORMAL - 4'h1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_r <= 4'h0;
    end else if (pre_tick) begin
      pre_cnt_r <= 4'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // ****************************************
  // divisor counter
  // ****************************************
  // output = input / divisor = 16 x baud
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= 16'h0000;
      tick      <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (divisor == 16'h0000) begin
        div_cnt_r <= 16'h0000;
      end else if (pre_tick) begin
        if (div_cnt_r >= divisor - 16'h0001) begin
          div_cnt_r <= 16'h0000;
          tick      <= 1'b1; // divisor 1 in fast mode: 2.5 Mbps
        end else begin
          div_cnt_r <= div_cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule : irrbg_baud

// >>> verilog/irrbg_pkg.sv
package irrbg_pkg;
  // ****************************************
  // register map (index on the address port)
  // ****************************************
  localparam logic [3:0] ADDR_DIV_LOW   = 4'h0;
  localparam logic [3:0] ADDR_DIV_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_VERSION   = 4'h2;
  localparam logic [3:0] ADDR_RX_STATUS = 4'h7;
  localparam logic [3:0] ADDR_RX_BUFFER = 4'h8;
  localparam logic [3:0] ADDR_CONTROL   = 4'h9;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'ha;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'hb;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'hc;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          BIT_RX_ACTIVE   = 7;
  localparam int          BIT_PULSE_DET   = 6;
  localparam int          BIT_HIGH_SPEED  = 1;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  DIV_RESET       = 8'h00;
  localparam logic [3:0]  PRESCALE_NORMAL = 4'hd;
  localparam logic [3:0]  PRESCALE_FAST   = 4'h1;
  localparam logic [3:0]  OVERSAMPLE      = 4'hf;
  localparam int          FIFO_DEPTH      = 16;
  // interrupt bits
  localparam int IRQ_PULSE = 0;
  localparam int IRQ_BYTE  = 1;
  localparam int IRQ_OVER  = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } irrbg_bus_t;
endpackage : irrbg_pkg

// >>> verilog/irrbg_top.sv
`timescale 1ns/1ps
// What this block does
// - a detected pulse on the ir input sets the receive-active flag.
// - writing 1 to the receive-active bit clears it and stops the receiver.
// - while active, the input is sampled at the baud rate into the fifo.
// - a detected pulse sets the read-only pulse-detected flag in bit 6.
// - reading the status register clears the pulse-detected flag.
// - bits 4 to 0 of the status register give the fifo byte count.
// - the status register resets to zero and bit 5 reads zero.
// - the divisor latch divides the baud generator input clock.
// - the generator output is sixteen times the baud rate.
// - high-speed mode feeds the 40 MHz clock straight to the divisor.
// - high-speed mode reaches 2.5 Mbps.
// - the version register is read-only and returns a fixed value.
// - normal mode prescales by 13, high-speed mode by 1.
module irrbg_top #(
  parameter logic [7:0] VERSION_VALUE = 8'h5a, // arbitrary value
  parameter int         DEPTH         = 16     // fifo depth, power of two
) (
  input  wire logic                clk,      // 40 MHz clock
  input  wire logic                reset_n,  // async reset, active low
  input  wire irrbg_pkg::irrbg_bus_t bus,    // register request
  output logic [7:0]               rdata,    // read data, cycle after rd
  input  wire logic                ir_in,    // raw ir receive pin
  output logic                     irq       // level interrupt
);
  import irrbg_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // the level field is five bits wide, so a full fifo of sixteen is the limit
  if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("DEPTH must be a power of two from 2 to 16");
  end

  // ****************************************
  // input synchroniser and pulse detection
  // ****************************************
  logic ir_meta_r;
  logic ir_sync_r;
  logic ir_prev_r;
  logic pulse;

  // two flops before any logic reads the pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ir_meta_r <= 1'b1;
      ir_sync_r <= 1'b1;
      ir_prev_r <= 1'b1;
    end else begin
      ir_meta_r <= ir_in;
      ir_sync_r <= ir_meta_r;
      ir_prev_r <= ir_sync_r;
    end
  end
  // idle line is high; a falling edge marks a pulse
  assign pulse = ir_prev_r && !ir_sync_r;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic       high_speed_r;
  logic       rx_active_r;
  logic       pulse_det_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_en_r;
  logic       wr_div_low;
  logic       wr_div_high;
  logic       wr_status;
  logic       rd_status;
  logic       rd_buffer;

  assign wr_div_low  = bus.wr && bus.addr == ADDR_DIV_LOW;
  assign wr_div_high = bus.wr && bus.addr == ADDR_DIV_HIGH;
  assign wr_status   = bus.wr && bus.addr == ADDR_RX_STATUS;
  assign rd_status   = bus.rd && bus.addr == ADDR_RX_STATUS;
  assign rd_buffer   = bus.rd && bus.addr == ADDR_RX_BUFFER;

  // divisor latches and mode bit; version writes fall through
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_low_r    <= DIV_RESET;
      div_high_r   <= DIV_RESET;
      high_speed_r <= 1'b0;
    end else begin
      if (wr_div_low) begin
        div_low_r <= bus.wdata;
      end
      if (wr_div_high) begin
        div_high_r <= bus.wdata;
      end
      if (bus.wr && bus.addr == ADDR_CONTROL) begin
        high_speed_r <= bus.wdata[BIT_HIGH_SPEED];
      end
    end
  end

  // receive-active: pulse sets, write-one clears; set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_active_r <= STATUS_RESET[BIT_RX_ACTIVE];
    end else if (pulse) begin
      rx_active_r <= 1'b1;
    end else if (wr_status && bus.wdata[BIT_RX_ACTIVE]) begin
      rx_active_r <= 1'b0;
    end
  end

  // pulse-detected: cleared by a status read unless a pulse lands then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_det_r <= STATUS_RESET[BIT_PULSE_DET];
    end else if (pulse) begin
      pulse_det_r <= 1'b1;
    end else if (rd_status) begin
      pulse_det_r <= 1'b0;
    end
  end

  // ****************************************
  // baud generator
  // ****************************************
  logic        tick;
  logic [15:0] divisor;

  assign divisor = {div_high_r, div_low_r};

  irrbg_baud u_baud (
    .clk        (clk),
    .reset_n    (reset_n),
    .high_speed (high_speed_r),
    .divisor    (divisor),
    .tick       (tick)
  );

  // ****************************************
  // sampler: mid-bit sample of 16x ticks, lsb first
  // ****************************************
  logic [3:0] phase_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic       byte_done_r;
  logic [7:0] byte_r;

  // samples only while active; a stopped receiver drops its partial byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r     <= 4'h0;
      bit_cnt_r   <= 3'h0;
      shift_r     <= 8'h00;
      byte_r      <= 8'h00;
      byte_done_r <= 1'b0;
    end else begin
      byte_done_r <= 1'b0;
      if (!rx_active_r) begin
        phase_r   <= 4'h0;
        bit_cnt_r <= 3'h0;
      end else if (tick) begin
        phase_r <= phase_r + 4'h1;
        if (phase_r == (OVERSAMPLE >> 1)) begin
          shift_r   <= {ir_sync_r, shift_r[7:1]};
          bit_cnt_r <= bit_cnt_r + 3'h1;
          if (bit_cnt_r == 3'h7) begin
            byte_r      <= {ir_sync_r, shift_r[7:1]};
            byte_done_r <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // receive fifo, flip-flop storage
  // ****************************************
  logic [7:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;
  logic          overrun;

  // a full fifo drops the new byte and flags an overrun
  assign push    = byte_done_r && (count_r != (AW+1)'(DEPTH));
  assign overrun = byte_done_r && !push;
  assign pop     = rd_buffer && (count_r != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= byte_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r    <= '0;
      rp_r    <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ****************************************
  // interrupts: sticky status, enable, write-one clear
  // ****************************************
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;

  assign irq_evt = {overrun, push, pulse};
  assign irq_clr = (bus.wr && bus.addr == ADDR_IRQ_CLR) ? bus.wdata[2:0] : 3'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= 3'h0;
      irq_en_r   <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (bus.wr && bus.addr == ADDR_IRQ_EN) begin
        irq_en_r <= bus.wdata[2:0];
      end
      irq <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_en_r);
    end
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  logic [4:0] level;

  assign level = 5'(count_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_DIV_LOW:   rdata <= div_low_r;
        ADDR_DIV_HIGH:  rdata <= div_high_r;
        ADDR_VERSION:   rdata <= VERSION_VALUE;
        ADDR_RX_STATUS: rdata <= {rx_active_r, pulse_det_r, 1'b0, level};
        ADDR_RX_BUFFER: rdata <= (count_r != '0) ? mem_r[rp_r] : 8'h00;
        ADDR_CONTROL:   rdata <= {6'h00, high_speed_r, 1'b0};
        ADDR_IRQ_STAT:  rdata <= {5'h00, irq_stat_r};
        ADDR_IRQ_EN:    rdata <= {5'h00, irq_en_r};
        default:        rdata <= 8'h00; // unmapped and write-only read zero
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_pulse_sets_active;
    @(posedge clk) disable iff (!reset_n) pulse |=> rx_active_r && pulse_det_r;
  endproperty
  a_pulse_sets_active: assert property (p_pulse_sets_active)
    else $error("pulse did not set flags");

  property p_clear_active;
    @(posedge clk) disable iff (!reset_n)
      (wr_status && bus.wdata[BIT_RX_ACTIVE] && !pulse) |=> !rx_active_r;
  endproperty
  a_clear_active: assert property (p_clear_active)
    else $error("write one did not clear active");

  property p_no_sample_idle;
    @(posedge clk) disable iff (!reset_n) !rx_active_r |=> !byte_done_r;
  endproperty
  a_no_sample_idle: assert property (p_no_sample_idle)
    else $error("byte produced while inactive");

  property p_read_clears_pd;
    @(posedge clk) disable iff (!reset_n) (rd_status && !pulse) |=> !pulse_det_r;
  endproperty
  a_read_clears_pd: assert property (p_read_clears_pd)
    else $error("status read did not clear pulse flag");

  sequence s_status_read;
    rd_status ##1 1'b1;
  endsequence
  property p_status_level;
    @(posedge clk) disable iff (!reset_n)
      s_status_read |-> rdata[4:0] == $past(level) && rdata[5] == 1'b0;
  endproperty
  a_status_level: assert property (p_status_level)
    else $error("status level or reserved bit wrong");

  property p_version_fixed;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == ADDR_VERSION) |=> rdata == VERSION_VALUE;
  endproperty
  a_version_fixed: assert property (p_version_fixed)
    else $error("version value wrong");

  property p_divisor_hold;
    @(posedge clk) disable iff (!reset_n)
      (divisor == 16'h0000) |=> !tick;
  endproperty
  a_divisor_hold: assert property (p_divisor_hold)
    else $error("tick with zero divisor");

  property p_fast_tick;
    @(posedge clk) disable iff (!reset_n)
      (high_speed_r && divisor == 16'h0001) [*3] |=> tick;
  endproperty
  a_fast_tick: assert property (p_fast_tick)
    else $error("fast mode divisor 1 not ticking each cycle");

  property p_pd_sticky;
    @(posedge clk) disable iff (!reset_n) (pulse_det_r && !rd_status) |=> pulse_det_r;
  endproperty
  a_pd_sticky: assert property (p_pd_sticky)
    else $error("pulse flag dropped without a status read");

  property p_fifo_bound;
    @(posedge clk) disable iff (!reset_n) count_r <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo level beyond depth");

  property p_pop_level;
    @(posedge clk) disable iff (!reset_n)
      (pop && !push) |=> count_r == $past(count_r) - (AW+1)'(1);
  endproperty
  a_pop_level: assert property (p_pop_level)
    else $error("buffer read did not lower the level");
endmodule : irrbg_top
